// ===== verif/ddc_channel_control_regs_bench.sv
// Directed bench for the channel control bank
`timescale 1ns/1ps
`include "ddc_channel_control_regs.vh"
module ddc_channel_control_regs_bench;
   localparam FPN = 1;
   reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, filter_out_valid;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata, v;
   reg  [3:0]  wstrb;
   reg  [2:0]  awprot, arprot, input_exponent;
   reg  [5:0]  sync_events;
   reg  [1:0]  r;
   wire        awready, wready, bvalid, arready, rvalid, channel_hold, mixer_round_20;
   wire        phase_apply, freq_apply, oscillator_init, dither_clear, pad_enable, pad_align;
   wire        dec_resync, gain_apply, flush_active, output_negate;
   wire        real_split_mode, inphase_half_flag, quadrature_half_flag;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [2:0]  mixer_shift;
   wire [5:0]  prescale_bits;
   wire [11:0] dec_word;
   wire [15:0] fine_gain;
   wire [3:0]  pad_count;
   integer     fails = 0, samples_checked = 0, i, n;

   ddc_channel_control_regs #(.FLUSH_PER_N(FPN)) ddc_channel_control_regs_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .sync_events(sync_events),
      .input_exponent(input_exponent), .filter_out_valid(filter_out_valid), .channel_hold(channel_hold),
      .mixer_shift(mixer_shift), .mixer_round_20(mixer_round_20), .prescale_bits(prescale_bits),
      .dec_word(dec_word), .fine_gain(fine_gain), .phase_apply(phase_apply), .freq_apply(freq_apply),
      .oscillator_init(oscillator_init), .dither_clear(dither_clear), .pad_enable(pad_enable),
      .pad_count(pad_count), .pad_align(pad_align), .dec_resync(dec_resync), .gain_apply(gain_apply),
      .flush_active(flush_active), .output_negate(output_negate), .real_split_mode(real_split_mode),
      .inphase_half_flag(inphase_half_flag), .quadrature_half_flag(quadrature_half_flag));

   // 100 ns clock
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task end_of_test;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input [31:0] s, input [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // Write one word; the extra edge lets the new value reach the outputs
   task wr(input [7:0] a, input [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      r = bresp;
      bready <= 1'b0;
      if (bvalid !== 1'b1) begin
         fails++;
         end_of_test;
      end
      @(posedge aclk);
   endtask

   // Read one word with its response code
   task rd(input [7:0] a, output [31:0] d, output [1:0] s);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      d = rdata;
      s = rresp;
      rready <= 1'b0;
      if (rvalid !== 1'b1) begin
         fails++;
         end_of_test;
      end
      @(posedge aclk);
   endtask

   // One-cycle sync strobe; returns where its registered effect is sampled
   task ev(input integer b);
      sync_events <= 6'h01 << b;
      @(posedge aclk);
      sync_events <= 6'h00;
      @(posedge aclk);
   endtask

   // One second-filter output; returns where the sign is sampled
   task fv;
      filter_out_valid <= 1'b1;
      @(posedge aclk);
      filter_out_valid <= 1'b0;
      @(posedge aclk);
   endtask

   // Fires the flush sync and counts the cycles that flush_active stands
   task fm;
      ev(2);
      n = 0;
      while (flush_active === 1'b1 && n < 99) begin
         n++;
         @(posedge aclk);
      end
      if (n == 99) begin
         fails++;
         end_of_test;
      end
   endtask

   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, filter_out_valid} = 7'h00;
      {awaddr, araddr, wdata, awprot, arprot, sync_events} = 60'h0;
      wstrb = 4'hf;
      input_exponent = 3'h3;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(channel_hold, 1'b1);
      for (i = 16; i < 31; i++) begin
         rd({i[5:0], 2'b00}, v, r);
         chk(v, i == 16 ? 32'h0000_0080 : 32'h0000_0000);
      end
      $display("test reset done");
      for (i = 16; i < 31; i++) begin
         wr({i[5:0], 2'b00}, 32'h0000_c3a5 ^ i);
         chk({30'h0, r}, {30'h0, `RESP_OKAY});
         rd({i[5:0], 2'b00}, v, r);
         chk(v, i == 30 ? 32'h0000_c3a5 ^ i : 32'h0000_00a5 ^ i);
         chk({30'h0, r}, {30'h0, `RESP_OKAY});
      end
      wr(8'h80, 32'h0000_00ff);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR});
      rd(8'h80, v, r);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR});
      $display("test sweep done");
      wr(8'h40, 32'h0000_000d);
      wr(8'h5c, 32'h0000_004a);
      chk({channel_hold, mixer_shift}, 4'h5);
      chk({mixer_round_20, prescale_bits}, {1'b1, 6'h31});
      wr(8'h40, 32'h0000_0000);
      chk({mixer_shift, prescale_bits}, {3'h3, 6'h33});
      wr(8'h60, 32'h0000_0015);
      chk({real_split_mode, inphase_half_flag, quadrature_half_flag}, 3'b100);
      wr(8'h60, 32'h0000_0065);
      chk({real_split_mode, inphase_half_flag, quadrature_half_flag}, 3'b011);
      $display("test controls done");
      wr(8'h44, 32'h0000_0052);
      ev(0);
      chk({phase_apply, freq_apply}, 2'b10);
      ev(3);
      chk({phase_apply, freq_apply}, 2'b01);
      wr(8'h44, 32'h0000_0011);
      chk({phase_apply, freq_apply}, 2'b11);
      wr(8'h48, 32'h0000_0055);
      ev(3);
      chk({oscillator_init, dither_clear}, 2'b11);
      wr(8'h48, 32'h0000_0010);
      chk({oscillator_init, dither_clear}, 2'b01);
      wr(8'h4c, 32'h0000_00a9);
      chk({pad_enable, pad_count}, 5'h19);
      ev(0);
      chk(pad_align, 1'b1);
      wr(8'h54, 32'h0000_0007);
      wr(8'h58, 32'h0000_0060);
      wr(8'h78, 32'h0000_1234);
      chk(dec_word, 12'h007);
      ev(4);
      chk(fine_gain, 16'h1234);
      chk(gain_apply, 1'b1);
      $display("test syncs done");
      wr(8'h50, 32'h0000_0043);
      fv;
      chk(output_negate, 1'b1);
      fv;
      chk(output_negate, 1'b0);
      ev(1);
      chk(dec_resync, 1'b1);
      fv;
      chk(output_negate, 1'b1);
      fm;
      chk(n, FPN * 8);
      wr(8'h60, 32'h0000_0015);
      fm;
      chk(n, FPN * 4);
      wr(8'h40, 32'h0000_0080);
      ev(1);
      chk({channel_hold, dec_resync}, 2'b10);
      $display("test flush done");
      end_of_test;
   end
endmodule // ddc_channel_control_regs_bench

// ===== verif/ddc_channel_control_regs_properties.sv
// Port-level assertions for the channel control bank
`timescale 1ns/1ps
module ddc_channel_control_regs_properties #(
   parameter FLUSH_PER_N = 24
) (
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Bus handshakes
   input wire        awready,
   input wire        wready,
   input wire        bvalid,
   input wire        bready,
   input wire [1:0]  bresp,
   input wire        arready,
   input wire        rvalid,
   input wire        rready,
   input wire [31:0] rdata,
   // Channel controls
   input wire        channel_hold,
   input wire        flush_active,
   input wire        dec_resync,
   input wire        gain_apply,
   input wire [11:0] dec_word,
   input wire        real_split_mode,
   input wire        output_negate
);
   reg  [17:0] run;
   wire [12:0] n_dec;
   // Split mode halves N, so the flush is half as long
   assign n_dec = real_split_mode ? ({1'b0, dec_word} + 13'h0001) >> 1 : {1'b0, dec_word} + 13'h0001;
   // Length of the current flush run
   always @(posedge aclk) begin
      if (!aresetn || !flush_active)
         run <= 18'h0_0000;
      else
         run <= run + 18'h0_0001;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_hold_reset; $rose(aresetn) |-> channel_hold; endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("hold bit clear after reset");
   property p_hold_quiet; channel_hold && $past(channel_hold) |-> !flush_active && !dec_resync && !gain_apply;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("activity while channel held");
   property p_flush_len; $fell(flush_active) && !channel_hold |-> run == FLUSH_PER_N * n_dec; endproperty
   a_flush_len: assert property (p_flush_len) else $error("flush length wrong");
   property p_b_stand; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_stand: assert property (p_b_stand) else $error("write response dropped");
   property p_r_stand; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_stand: assert property (p_r_stand) else $error("read data dropped");
   property p_aw_pulse; awready |=> !awready; endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than a cycle");
   property p_ar_rvalid; arready |-> rvalid; endproperty
   a_ar_rvalid: assert property (p_ar_rvalid) else $error("read taken without data");
   property p_b_after; $rose(bvalid) |-> $past(awready) || $past(wready); endproperty
   a_b_after: assert property (p_b_after) else $error("response before transfer");
   // Main scenarios reached
   c_flush: cover property ($fell(flush_active));
   c_read: cover property (rvalid && rready);
   c_negate: cover property ($rose(output_negate));
endmodule // ddc_channel_control_regs_properties

bind ddc_channel_control_regs ddc_channel_control_regs_properties #(.FLUSH_PER_N(FLUSH_PER_N))
   ddc_channel_control_regs_properties_inst (.aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arready(arready), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .channel_hold(channel_hold), .flush_active(flush_active), .dec_resync(dec_resync),
      .gain_apply(gain_apply), .dec_word(dec_word), .real_split_mode(real_split_mode),
      .output_negate(output_negate));

// ===== verilog/ddc_channel_control_regs.v
// Per-channel control register bank of a downconverter channel, with an AXI4-Lite slave
`timescale 1ns/1ps
`include "ddc_channel_control_regs.vh"

// Behaviour
// - Hold bit high keeps channel reset; powers up 0x80
// - Manual shift select chooses register or input exponent
// - Phase and frequency apply on their selected syncs
// - Continuous selection applies new values immediately
// - Oscillator accumulator loads phase on selected sync
// - Dither cleared on selected sync; continuous disables
// - Zero padding count and alignment sync when enabled
// - Decimation counter resyncs on selected decimation sync
// - Flush runs 24N clocks after flush sync
// - Fine gain applies on sync in high ratio byte
// - Rounding bit selects 20 or 16 bit mixer output
// - Prescale is 62 minus shift, scale, six coarse
// - Sign pattern negates successive second filter outputs
// - Split bit selects real-only double throughput mode
// - Flags force in-phase or quadrature only outputs
// - All control registers readable and writable by software
module ddc_channel_control_regs #(
   parameter FLUSH_PER_N = `FLUSH_PER_N
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [7:0]  awaddr,
   input  wire [2:0]  awprot,
   input  wire        awvalid,
   output reg         awready,
   // AXI4-Lite write data
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   // AXI4-Lite write response
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   // AXI4-Lite read address
   input  wire [7:0]  araddr,
   input  wire [2:0]  arprot,
   input  wire        arvalid,
   output reg         arready,
   // AXI4-Lite read data
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   // Chip-wide sync strobes for selector codes 2 to 7
   input  wire [5:0]  sync_events,
   // Datapath inputs
   input  wire [2:0]  input_exponent,
   input  wire        filter_out_valid,
   // Channel controls
   output reg         channel_hold,
   output reg  [2:0]  mixer_shift,
   output reg         mixer_round_20,
   output reg  [5:0]  prescale_bits,
   output reg  [11:0] dec_word,
   output reg  [15:0] fine_gain,
   // Sync-driven events, with the zero padding enable and count
   output reg         phase_apply,
   output reg         freq_apply,
   output reg         oscillator_init,
   output reg         dither_clear,
   output reg         pad_enable,
   output reg  [3:0]  pad_count,
   output reg         pad_align,
   output reg         dec_resync,
   output reg         gain_apply,
   output reg         flush_active,
   // Output formatting
   output reg         output_negate,
   output reg         real_split_mode,
   output reg         inphase_half_flag,
   output reg         quadrature_half_flag
);

   // Byte registers 0x10..0x1d, addressed by index minus 0x10
   // Only the channel reset register leaves reset non-zero
   reg  [7:0]  ctl [0:13];
   reg  [15:0] fine_gain_reg;
   reg  [5:0]  aw_idx;
   reg         aw_bad;
   reg         aw_got;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_got;
   reg  [17:0] flush_left;
   reg  [1:0]  sign_idx;
   integer     i;

   // Decodes a sync selector against the shared source set
   function sync_hit;
      input [2:0] sel;
      input [5:0] ev;
      begin
         case (sel)
            `SYNC_NEVER:  sync_hit = 1'b0;
            `SYNC_ALWAYS: sync_hit = 1'b1;
            // Codes 2 to 7 map onto the six chip-wide strobe lines
            default:      sync_hit = ev[sel - 3'h2];
         endcase
      end
   endfunction

   // Address decode: word aligned and inside the bank
   function addr_ok;
      input [7:0] a;
      begin
         // Bits 7:6 equal to 01 select byte addresses 0x40 to 0x7f
         addr_ok = (a[1:0] == 2'b00) && (a[7:6] == 2'b01);
      end
   endfunction

   // Named views of the stored fields
   wire [7:0]  r_chan  = ctl[0];
   wire [7:0]  r_pfsel = ctl[1];
   wire [7:0]  r_osel  = ctl[2];
   wire [7:0]  r_pad   = ctl[3];
   wire [7:0]  r_dsel  = ctl[4];
   wire [7:0]  r_declo = ctl[5];
   wire [7:0]  r_dechi = ctl[6];
   wire [7:0]  r_cic   = ctl[7];
   wire [7:0]  r_split = ctl[8];
   wire        hold    = r_chan[`POS_CHANNEL_HOLD];
   wire        split   = r_split[`POS_REAL_SPLIT];
   wire [11:0] dec_val = {r_dechi[3:0], r_declo};

   // Ratio N from the decimation word; split mode stores 2N-1
   wire [12:0] ratio_n = split ? ({1'b0, dec_val} + 13'h0001) >> 1
                               : {1'b0, dec_val} + 13'h0001;
   // Full product first, then cut on purpose: the largest flush fits 18 bits
   wire [31:0] flush_prod = ratio_n * FLUSH_PER_N;
   wire [17:0] flush_len  = flush_prod[17:0];

   // Shift source: register field or input exponent
   wire [2:0]  shift_now = r_chan[`POS_USE_SHIFT] ? r_chan[2:0] : input_exponent;

   // Comb prescale: 62 - shift - scale - 6 * coarse
   // Six times coarse built as four times plus two times, without a multiplier
   wire [6:0]  coarse6 = {1'b0, r_cic[5:3], 2'b00} + {2'b00, r_cic[5:3], 1'b0};
   wire [6:0]  prescale_next = `PRESCALE_BASE - {4'h0, shift_now}
                               - {4'h0, r_cic[2:0]} - coarse6;

   // Write target index
   wire [5:0]  w_slot = aw_idx - `IDX_CHANNEL_RESET_AND_GAIN_SHIFT;
   wire        do_write = aw_got && w_got && !bvalid;

   // Write address and data channels, taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         aw_got  <= 1'b0;
         w_got   <= 1'b0;
         aw_idx  <= 6'h00;
         aw_bad  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         awready <= 1'b0;
         wready  <= 1'b0;
         if (awvalid && !aw_got && !awready) begin
            awready <= 1'b1;
            aw_got  <= 1'b1;
            aw_idx  <= awaddr[7:2];
            aw_bad  <= !addr_ok(awaddr);
         end
         if (wvalid && !w_got && !wready) begin
            wready <= 1'b1;
            w_got  <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         // A second beat waits until the pending write has landed
         // Both halves are released together when the write lands
         if (do_write) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR
   // The response stands until taken; no new write lands meanwhile
   always @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= aw_bad ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Register storage; status index ignores writes
   // Byte registers take lane 0 only; the other lanes are dropped
   always @(posedge aclk) begin
      if (!aresetn) begin
         for (i = 0; i < 14; i = i + 1) begin
            ctl[i] <= `RST_BYTE;
         end
         ctl[0]        <= `RST_CHANNEL_RESET;
         fine_gain_reg <= `RST_FINE_GAIN;
      end else if (do_write && !aw_bad) begin
         if (aw_idx == `IDX_FINE_GAIN_WORD) begin
            if (w_strb[0]) fine_gain_reg[7:0]  <= w_data[7:0];
            if (w_strb[1]) fine_gain_reg[15:8] <= w_data[15:8];
         end else if (aw_idx < `IDX_FINE_GAIN_WORD && w_strb[0]) begin
            ctl[w_slot[3:0]] <= w_data[7:0];
         end
      end
   end

   // Read channel; one read at a time
   // Data is formed at acceptance, so it stands unchanged while rvalid waits
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RESP_OKAY;
      end else begin
         arready <= 1'b0;
         if (rvalid) begin
            if (rready) rvalid <= 1'b0;
         end else if (arvalid && !arready) begin
            arready <= 1'b1;
            rvalid  <= 1'b1;
            rresp   <= `RESP_OKAY;
            rdata   <= 32'h0000_0000;
            if (!addr_ok(araddr)) begin
               rresp <= `RESP_SLVERR;
            end else if (araddr[7:2] == `IDX_CHANNEL_STATUS) begin
               rdata <= {28'h000_0000, sign_idx, flush_active, hold};
            end else if (araddr[7:2] == `IDX_FINE_GAIN_WORD) begin
               rdata <= {16'h0000, fine_gain_reg};
            end else begin
               rdata <= {24'h00_0000, ctl[araddr[5:2]]};
            end
         end
      end
   end

   // Static controls follow the registers one cycle later
   // The extra cycle keeps every output straight from a flip-flop
   always @(posedge aclk) begin
      if (!aresetn) begin
         channel_hold         <= 1'b1;
         mixer_shift          <= 3'h0;
         mixer_round_20       <= 1'b0;
         prescale_bits        <= 6'h00;
         dec_word             <= 12'h000;
         pad_enable           <= 1'b0;
         pad_count            <= 4'h0;
         real_split_mode      <= 1'b0;
         inphase_half_flag    <= 1'b0;
         quadrature_half_flag <= 1'b0;
      end else begin
         channel_hold         <= hold;
         mixer_shift          <= shift_now;
         mixer_round_20       <= r_cic[`POS_WIDE_ROUNDING];
         prescale_bits        <= prescale_next[5:0];
         dec_word             <= dec_val;
         pad_enable           <= r_pad[`POS_PAD_ENABLE];
         pad_count            <= r_pad[3:0];
         real_split_mode      <= split;
         inphase_half_flag    <= r_split[`POS_INPHASE_HALF];
         quadrature_half_flag <= r_split[`POS_QUADRATURE_HALF];
      end
   end

   // Sync-driven strobes; a held channel sees no syncs because hold keeps every strobe cleared
   always @(posedge aclk) begin
      if (!aresetn || hold) begin
         phase_apply     <= 1'b0;
         freq_apply      <= 1'b0;
         oscillator_init <= 1'b0;
         dither_clear    <= 1'b0;
         pad_align       <= 1'b0;
         dec_resync      <= 1'b0;
         gain_apply      <= 1'b0;
         fine_gain       <= `RST_FINE_GAIN;
      end else begin
         // Continuous selection fires every cycle, so new values land at once
         phase_apply     <= sync_hit(r_pfsel[2:0], sync_events);
         freq_apply      <= sync_hit(r_pfsel[6:4], sync_events);
         oscillator_init <= sync_hit(r_osel[2:0], sync_events);
         // The never code leaves dither free running
         // Held high under continuous selection, which disables dither
         dither_clear    <= sync_hit(r_osel[6:4], sync_events);
         pad_align       <= r_pad[`POS_PAD_ENABLE] && sync_hit(r_pad[6:4], sync_events);
         dec_resync      <= sync_hit(r_dsel[2:0], sync_events);
         gain_apply      <= sync_hit(r_dechi[6:4], sync_events);
         if (sync_hit(r_dechi[6:4], sync_events)) begin
            fine_gain <= fine_gain_reg;
         end
      end
   end

   // Flush timer; a later flush sync restarts the full length
   // The length is fixed at the sync; a later ratio change needs a new flush
   always @(posedge aclk) begin
      if (!aresetn || hold) begin
         flush_left   <= 18'h0_0000;
         flush_active <= 1'b0;
      end else if (sync_hit(r_dsel[6:4], sync_events)) begin
         flush_left   <= flush_len;
         flush_active <= 1'b1;
      end else if (flush_left != 18'h0_0000) begin
         flush_left   <= flush_left - 18'h0_0001;
         flush_active <= (flush_left != 18'h0_0001);
      end else begin
         flush_active <= 1'b0;
      end
   end

   // Sign pattern walks one bit per second filter output
   // Only the low four bits of the split register form the pattern
   always @(posedge aclk) begin
      if (!aresetn || hold) begin
         sign_idx      <= 2'b00;
         output_negate <= 1'b0;
      end else if (sync_hit(r_dsel[2:0], sync_events)) begin
         // Realign the pattern with the decimation counter
         sign_idx      <= 2'b00;
         output_negate <= 1'b0;
      end else if (filter_out_valid) begin
         output_negate <= r_split[sign_idx];
         sign_idx      <= sign_idx + 2'b01;
      end
   end

endmodule // ddc_channel_control_regs

// ===== verilog/ddc_channel_control_regs.vh
// Offsets, field positions, reset values and timing counts of the channel control bank
`ifndef DDC_CHANNEL_CONTROL_REGS_VH
`define DDC_CHANNEL_CONTROL_REGS_VH

// Register indexes; byte address is four times the index
`define IDX_CHANNEL_RESET_AND_GAIN_SHIFT  6'h10
`define IDX_PHASE_TUNING_UPDATE_SELECT_SELECT        6'h11
`define IDX_OSCILLATOR_DITHER_SYNC_SELECT 6'h12
`define IDX_ZERO_PAD_CONTROL              6'h13
`define IDX_DECIMATION_FLUSH_SYNC_SELECT  6'h14
`define IDX_RATIO_WORD_LOW                6'h15
`define IDX_RATIO_WORD_HIGH_GAIN_SYNC     6'h16
`define IDX_COMB_PRESCALE_ROUNDING        6'h17
`define IDX_SPLIT_AND_SIGN_CONTROL        6'h18
`define IDX_QUARTER_DELAY_COARSE_GAIN     6'h19
`define IDX_HALF_DELAY_SYMMETRY           6'h1a
`define IDX_INPUT_PORT_FORMAT             6'h1b
`define IDX_OVERFLOW_COUNTER_CONTROL      6'h1c
`define IDX_OVERFLOW_COUNT_READBACK       6'h1d
`define IDX_FINE_GAIN_WORD                6'h1e
`define IDX_CHANNEL_STATUS                6'h1f

// Reset values
`define RST_CHANNEL_RESET                 8'h80
`define RST_BYTE                          8'h00
`define RST_FINE_GAIN                     16'h0000

// Field positions (low bit of each field)
`define POS_LOW_SELECT                    0
`define POS_HIGH_SELECT                   4
`define POS_USE_SHIFT                     3
`define POS_CHANNEL_HOLD                  7
`define POS_PAD_ENABLE                    7
`define POS_SCALE                         0
`define POS_COARSE                        3
`define POS_WIDE_ROUNDING                 6
`define POS_REAL_SPLIT                    4
`define POS_INPHASE_HALF                  5
`define POS_QUADRATURE_HALF               6

// Sync selector codes
`define SYNC_NEVER                        3'h0
`define SYNC_ALWAYS                       3'h1

// Prescale base and flush length per unit of decimation
`define PRESCALE_BASE                     7'h3e
`define FLUSH_PER_N                       24

// Bus responses
`define RESP_OKAY                         2'h0
`define RESP_SLVERR                       2'h2

`endif
